// ### hw/rca_pkg.sv
// constants, codes and bus carrier for the clock/calendar unit
package rca_pkg;
  // register bus geometry
  localparam int AW = 3;
  localparam int DW = 16;
  // register word addresses
  localparam logic [AW-1:0] A_CFG = 3'h0; // clock_config_trim
  localparam logic [AW-1:0] A_PAD = 3'h1; // pad_output_select
  localparam logic [AW-1:0] A_ALCFG = 3'h2; // alarm_config_repeat
  localparam logic [AW-1:0] A_TVAL = 3'h3; // time window high/low
  localparam logic [AW-1:0] A_AVAL = 3'h4; // alarm window high/low
  localparam logic [AW-1:0] A_KEY = 3'h5; // unlock_key_register
  // field positions
  localparam int B_ON = 15;
  localparam int B_UNLK = 13;
  localparam int B_SYNC = 12;
  localparam int B_HALF = 11;
  localparam int B_OE = 10;
  localparam int B_PSEL = 1;
  localparam int B_ALON = 15;
  localparam int B_CHIME = 14;
  // unlock key bytes
  localparam logic [7:0] KEY_FIRST = 8'h55;
  localparam logic [7:0] KEY_SECOND = 8'haa;
  // window pointer codes
  localparam logic [1:0] P_MS = 2'h0;
  localparam logic [1:0] P_WH = 2'h1;
  localparam logic [1:0] P_MD = 2'h2;
  localparam logic [1:0] P_YR = 2'h3;
  // crystal prescaler: 32768 pulses a second
  localparam logic [15:0] SEC_END = 16'h7fff;
  localparam logic [15:0] HALF_END = 16'h3fff;
  localparam logic [14:0] RIPPLE_START = 15'h7fe0;
  // bcd limits and reset calendar values
  localparam logic [7:0] BCD_59 = 8'h59;
  localparam logic [7:0] BCD_23 = 8'h23;
  localparam logic [7:0] BCD_12 = 8'h12;
  localparam logic [7:0] BCD_99 = 8'h99;
  localparam logic [2:0] WD_LAST = 3'h6;
  localparam logic [7:0] BCD_ONE = 8'h01;
  // alarm period codes
  typedef enum logic [3:0] {
    AM_HALF = 4'b0000, AM_SEC = 4'b0001, AM_TSEC = 4'b0010,
    AM_MIN = 4'b0011, AM_TMIN = 4'b0100, AM_HOUR = 4'b0101,
    AM_DAY = 4'b0110, AM_WEEK = 4'b0111, AM_MONTH = 4'b1000,
    AM_YEAR = 4'b1001
  } rca_mask_type;
  // unlock key sequence states
  typedef enum logic [1:0] {
    KS_IDLE = 2'b00, KS_GOT1 = 2'b01, KS_ARMED = 2'b10
  } rca_key_type;
  // register bus request
  typedef struct packed {
    logic [AW-1:0] addr;
    logic [DW-1:0] wdata;
    logic [1:0] be;
    logic wr;
    logic rd;
  } rca_bus_type;
endpackage : rca_pkg

// ### hw/rca_top.sv
// clock/calendar with alarm, calibration and pin output
`timescale 1ns/1ps
module rca_top (
  input wire logic i_clk_sys,
  input wire logic i_srst,
  input wire logic i_por,
  input wire logic i_xtal_tick,
  input wire rca_pkg::rca_bus_type i_bus,
  output logic [rca_pkg::DW-1:0] o_rdata,
  output logic o_pin,
  output logic o_pin_oe,
  output logic o_alarm_event
);
  import rca_pkg::*;

  // bcd increment of a two-digit value
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == 4'h9) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = v + 8'h01;
    end
  endfunction : bcd_inc

  // window pointer step, sticks at 00
  function automatic logic [1:0] ptr_dec(input logic [1:0] p);
    ptr_dec = (p == P_MS) ? P_MS : p - 2'h1;
  endfunction : ptr_dec

  // last day of month, leap years of 2000-2099
  function automatic logic [7:0] month_end(input logic [7:0] m, input logic [7:0] y);
    logic leap;
    leap = y[4] ? (y[3:0] == 4'h2 || y[3:0] == 4'h6)
                : (y[3:0] == 4'h0 || y[3:0] == 4'h4 || y[3:0] == 4'h8);
    if (m == 8'h02) begin
      month_end = leap ? 8'h29 : 8'h28;
    end else if (m == 8'h04 || m == 8'h06 || m == 8'h09 || m == 8'h11) begin
      month_end = 8'h30;
    end else begin
      month_end = 8'h31;
    end
  endfunction : month_end

  // configuration state, por only except psel_q, which srst resets
  logic on_q, unlk_q, oe_q, psel_q;
  logic [1:0] tptr_q;
  logic [7:0] cal_q;
  // alarm configuration
  logic alon_q, chime_q;
  logic [3:0] alarm_period_select_q;
  logic [1:0] aptr_q;
  logic [7:0] rpt_q;
  // time fields, bcd
  logic [7:0] sec_q, min_q, hr_q, day_q, mon_q, yr_q;
  logic [2:0] wd_q;
  // alarm fields, bcd
  logic [7:0] asec_q, amin_q, ahr_q, aday_q, amon_q;
  logic [2:0] awd_q;
  // crystal prescaler and tick pipeline
  logic [15:0] cnt_q;
  logic tick_q, half_q;
  rca_key_type key_q;
  logic apulse_q;

  // bus decode
  logic wr_cfg, wr_pad, wr_alcfg, wr_tval, wr_aval, wr_key;
  logic rd_tval, rd_aval, tptr_step, aptr_step, armed;
  always_comb begin
    wr_cfg = 1'b0;
    wr_pad = 1'b0;
    wr_alcfg = 1'b0;
    wr_tval = 1'b0;
    wr_aval = 1'b0;
    wr_key = 1'b0;
    if (i_bus.addr == A_CFG) begin
      wr_cfg = i_bus.wr;
    end else if (i_bus.addr == A_PAD) begin
      wr_pad = i_bus.wr;
    end else if (i_bus.addr == A_ALCFG) begin
      wr_alcfg = i_bus.wr;
    end else if (i_bus.addr == A_TVAL) begin
      wr_tval = i_bus.wr;
    end else if (i_bus.addr == A_AVAL) begin
      wr_aval = i_bus.wr;
    end else if (i_bus.addr == A_KEY) begin
      wr_key = i_bus.wr;
    end
  end
  assign rd_tval = i_bus.rd && i_bus.addr == A_TVAL;
  assign rd_aval = i_bus.rd && i_bus.addr == A_AVAL;
  // either byte read steps, write only via high byte
  assign tptr_step = rd_tval || (wr_tval && i_bus.be[1]);
  assign aptr_step = rd_aval || (wr_aval && i_bus.be[1]);
  assign armed = key_q == KS_ARMED;

  // timing events from the crystal pulse
  logic sec_tick, half_tick, half_w, sync_w, sec_clr;
  assign sec_tick = on_q && i_xtal_tick && cnt_q == SEC_END;
  assign half_tick = on_q && i_xtal_tick && cnt_q == HALF_END;
  assign half_w = !cnt_q[15] && cnt_q[14];
  assign sync_w = on_q && !cnt_q[15] && cnt_q[14:0] >= RIPPLE_START;
  assign sec_clr = wr_tval && i_bus.be[0] && tptr_q == P_MS;

  // unlock key sequence, armed for one following access
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      key_q <= KS_IDLE;
    end else if (wr_key && i_bus.wdata[7:0] == KEY_FIRST) begin
      key_q <= KS_GOT1;
    end else if (wr_key && key_q == KS_GOT1 && i_bus.wdata[7:0] == KEY_SECOND) begin
      key_q <= KS_ARMED;
    end else if (i_bus.wr || i_bus.rd) begin
      key_q <= KS_IDLE;
    end
  end

  // configuration register, only por resets it
  always_ff @(posedge i_clk_sys) begin
    if (i_por) begin
      on_q <= 1'b0;
      unlk_q <= 1'b0;
      oe_q <= 1'b0;
      tptr_q <= P_MS;
      cal_q <= 8'h00;
    end else if (wr_cfg) begin
      if (i_bus.be[1]) begin
        // enable only changes when already unlocked
        if (unlk_q) begin
          on_q <= i_bus.wdata[B_ON];
        end
        // setting needs the key, clearing never does
        unlk_q <= i_bus.wdata[B_UNLK] && (unlk_q || armed);
        oe_q <= i_bus.wdata[B_OE];
        tptr_q <= i_bus.wdata[9:8];
      end
      if (i_bus.be[0]) begin
        cal_q <= i_bus.wdata[7:0];
      end
    end else if (tptr_step) begin
      tptr_q <= ptr_dec(tptr_q);
    end
  end

  // pad output select
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      psel_q <= 1'b0;
    end else if (wr_pad && i_bus.be[0]) begin
      psel_q <= i_bus.wdata[B_PSEL];
    end
  end

  // prescaler; trim loads a signed start at each minute
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || sec_clr) begin
      cnt_q <= 16'h0000;
    end else if (on_q && i_xtal_tick) begin
      if (cnt_q == SEC_END) begin
        // positive trim shortens, negative lengthens
        cnt_q <= (sec_q == BCD_59) ? {{6{cal_q[7]}}, cal_q, 2'b00} : 16'h0000;
      end else begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  // tick pipeline, alarm compares the updated time
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      tick_q <= 1'b0;
      half_q <= 1'b0;
    end else begin
      tick_q <= sec_tick || half_tick;
      half_q <= half_tick;
    end
  end

  // time keeping with software writes winning
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      sec_q <= 8'h00;
      min_q <= 8'h00;
      hr_q <= 8'h00;
      wd_q <= 3'h0;
      day_q <= BCD_ONE;
      mon_q <= BCD_ONE;
      yr_q <= 8'h00;
    end else begin
      if (sec_tick) begin
        sec_q <= (sec_q == BCD_59) ? 8'h00 : bcd_inc(sec_q);
        if (sec_q == BCD_59) begin
          min_q <= (min_q == BCD_59) ? 8'h00 : bcd_inc(min_q);
          if (min_q == BCD_59) begin
            hr_q <= (hr_q == BCD_23) ? 8'h00 : bcd_inc(hr_q);
            if (hr_q == BCD_23) begin
              wd_q <= (wd_q == WD_LAST) ? 3'h0 : wd_q + 3'h1;
              if (day_q == month_end(mon_q, yr_q)) begin
                day_q <= BCD_ONE;
                mon_q <= (mon_q == BCD_12) ? BCD_ONE : bcd_inc(mon_q);
                if (mon_q == BCD_12) begin
                  yr_q <= (yr_q == BCD_99) ? 8'h00 : bcd_inc(yr_q);
                end
              end else begin
                day_q <= bcd_inc(day_q);
              end
            end
          end
        end
      end
      if (wr_tval && unlk_q) begin
        // field pair chosen by the pointer
        case (tptr_q)
          P_MS: begin
            if (i_bus.be[1]) min_q <= {1'b0, i_bus.wdata[14:8]};
            if (i_bus.be[0]) sec_q <= {1'b0, i_bus.wdata[6:0]};
          end
          P_WH: begin
            if (i_bus.be[1]) wd_q <= i_bus.wdata[10:8];
            if (i_bus.be[0]) hr_q <= {2'b00, i_bus.wdata[5:0]};
          end
          P_MD: begin
            // month tens and ones are read-only
            if (i_bus.be[0]) day_q <= {2'b00, i_bus.wdata[5:0]};
          end
          default: begin
            if (i_bus.be[0]) yr_q <= i_bus.wdata[7:0];
          end
        endcase
      end
    end
  end

  // alarm field writes through the alarm window
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      asec_q <= 8'h00;
      amin_q <= 8'h00;
      ahr_q <= 8'h00;
      awd_q <= 3'h0;
      aday_q <= BCD_ONE;
      amon_q <= BCD_ONE;
    end else if (wr_aval) begin
      case (aptr_q)
        P_MS: begin
          if (i_bus.be[1]) amin_q <= {1'b0, i_bus.wdata[14:8]};
          if (i_bus.be[0]) asec_q <= {1'b0, i_bus.wdata[6:0]};
        end
        P_WH: begin
          if (i_bus.be[1]) awd_q <= i_bus.wdata[10:8];
          if (i_bus.be[0]) ahr_q <= {2'b00, i_bus.wdata[5:0]};
        end
        P_MD: begin
          if (i_bus.be[1]) amon_q <= {3'b000, i_bus.wdata[12:8]};
          if (i_bus.be[0]) aday_q <= {2'b00, i_bus.wdata[5:0]};
        end
        default: begin
          // unimplemented pair, write dropped
        end
      endcase
    end
  end

  // alarm match on the fields the period keeps
  logic hit, ev;
  always_comb begin
    case (alarm_period_select_q)
      AM_HALF: hit = 1'b1;
      AM_SEC: hit = !half_q;
      AM_TSEC: hit = !half_q && sec_q[3:0] == asec_q[3:0];
      AM_MIN: hit = !half_q && sec_q == asec_q;
      AM_TMIN: hit = !half_q && sec_q == asec_q && min_q[3:0] == amin_q[3:0];
      AM_HOUR: hit = !half_q && sec_q == asec_q && min_q == amin_q;
      AM_DAY: hit = !half_q && sec_q == asec_q && min_q == amin_q && hr_q == ahr_q;
      AM_WEEK: hit = !half_q && sec_q == asec_q && min_q == amin_q && hr_q == ahr_q
                     && wd_q == awd_q;
      AM_MONTH: hit = !half_q && sec_q == asec_q && min_q == amin_q && hr_q == ahr_q
                      && day_q == aday_q;
      // feb 29 only exists in leap years, so fires every fourth
      AM_YEAR: hit = !half_q && sec_q == asec_q && min_q == amin_q && hr_q == ahr_q
                     && day_q == aday_q && mon_q == amon_q;
      default: hit = 1'b0;
    endcase
  end
  assign ev = alon_q && tick_q && hit;

  // alarm configuration and repeat counting
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      alon_q <= 1'b0;
      chime_q <= 1'b0;
      alarm_period_select_q <= 4'h0;
      aptr_q <= P_MS;
      rpt_q <= 8'h00;
    end else if (wr_alcfg) begin
      if (i_bus.be[1]) begin
        alon_q <= i_bus.wdata[B_ALON];
        chime_q <= i_bus.wdata[B_CHIME];
        alarm_period_select_q <= i_bus.wdata[13:10];
        aptr_q <= i_bus.wdata[9:8];
      end
      if (i_bus.be[0]) begin
        rpt_q <= i_bus.wdata[7:0];
      end
    end else begin
      if (aptr_step) begin
        aptr_q <= ptr_dec(aptr_q);
      end
      if (ev) begin
        if (rpt_q != 8'h00) begin
          rpt_q <= rpt_q - 8'h01;
        end else if (chime_q) begin
          rpt_q <= 8'hff;
        end else begin
          alon_q <= 1'b0;
        end
      end
    end
  end

  // alarm pulse stretched to the next half second
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      apulse_q <= 1'b0;
      o_alarm_event <= 1'b0;
    end else begin
      o_alarm_event <= ev;
      if (ev) begin
        apulse_q <= 1'b1;
      end else if (half_tick || sec_tick) begin
        apulse_q <= 1'b0;
      end
    end
  end

  // pin drive: source select gated by output enable
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      o_pin <= 1'b0;
      o_pin_oe <= 1'b0;
    end else begin
      o_pin_oe <= oe_q;
      o_pin <= oe_q && (psel_q ? !half_w : apulse_q);
    end
  end

  // read data for one cycle after the strobe
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !i_bus.rd) begin
      o_rdata <= 16'h0000;
    end else if (i_bus.addr == A_CFG) begin
      o_rdata <= {on_q, 1'b0, unlk_q, sync_w, half_w, oe_q, tptr_q, cal_q};
    end else if (i_bus.addr == A_PAD) begin
      o_rdata <= {14'h0000, psel_q, 1'b0};
    end else if (i_bus.addr == A_ALCFG) begin
      o_rdata <= {alon_q, chime_q, alarm_period_select_q, aptr_q, rpt_q};
    end else if (i_bus.addr == A_TVAL) begin
      case (tptr_q)
        P_MS: o_rdata <= {1'b0, min_q[6:0], 1'b0, sec_q[6:0]};
        P_WH: o_rdata <= {5'h00, wd_q, 2'b00, hr_q[5:0]};
        P_MD: o_rdata <= {3'b000, mon_q[4:0], 2'b00, day_q[5:0]};
        default: o_rdata <= {8'h00, yr_q};
      endcase
    end else if (i_bus.addr == A_AVAL) begin
      case (aptr_q)
        P_MS: o_rdata <= {1'b0, amin_q[6:0], 1'b0, asec_q[6:0]};
        P_WH: o_rdata <= {5'h00, awd_q, 2'b00, ahr_q[5:0]};
        P_MD: o_rdata <= {3'b000, amon_q[4:0], 2'b00, aday_q[5:0]};
        default: o_rdata <= 16'h0000;
      endcase
    end else begin
      o_rdata <= 16'h0000;
    end
  end

  // checks
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_srst || i_por);

  chk_on_locked: assert property (
    wr_cfg && !unlk_q |=> on_q == $past(on_q)) else $error("enable changed while locked");
  chk_tval_lock: assert property (
    wr_tval && !unlk_q && !sec_tick |=> $stable({min_q, sec_q, hr_q, day_q, yr_q}))
    else $error("time written while locked");
  // a config read inside the last stretch before rollover must show the warning
  chk_sync_end: assert property (
    i_bus.rd && i_bus.addr == A_CFG && on_q && cnt_q >= 16'(RIPPLE_START)
    && cnt_q <= SEC_END |=> o_rdata[B_SYNC])
    else $error("no ripple warning near rollover");
  chk_half_clear: assert property (
    sec_clr |=> !half_w [*2]) else $error("half flag not cleared");
  chk_pin_gate: assert property (
    !oe_q |=> !o_pin && !o_pin_oe) else $error("pin driven while disabled");
  chk_tptr_dec: assert property (
    tptr_step && !wr_cfg && tptr_q != P_MS |=> tptr_q == $past(tptr_q) - 2'h1)
    else $error("time pointer did not step");
  chk_tptr_stop: assert property (
    tptr_step && !wr_cfg && tptr_q == P_MS |=> tptr_q == P_MS)
    else $error("time pointer left 00");
  chk_alarm_clear: assert property (
    ev && rpt_q == 8'h00 && !chime_q && !wr_alcfg |=> !alon_q)
    else $error("alarm not self-cleared");
  chk_chime_wrap: assert property (
    ev && rpt_q == 8'h00 && chime_q && !wr_alcfg |=> rpt_q == 8'hff && alon_q)
    else $error("chime did not wrap");
  chk_rpt_dec: assert property (
    ev && rpt_q != 8'h00 && !wr_alcfg |=> rpt_q == $past(rpt_q) - 8'h01)
    else $error("repeat count did not step");
  chk_alarm_out: assert property (
    ev |=> o_alarm_event ##1 !o_alarm_event || ev)
    else $error("alarm event not reported");
  chk_por_keep: assert property (@(posedge i_clk_sys) disable iff (i_por)
    i_srst && !wr_cfg && !tptr_step |=> $stable({on_q, unlk_q, oe_q, tptr_q, cal_q}))
    else $error("config changed by plain reset");

  cov_unlock: cover property (armed ##1 wr_cfg && i_bus.wdata[B_UNLK]);
  cov_alarm: cover property (ev);
  cov_minute: cover property (sec_tick && sec_q == BCD_59);
  cov_chime: cover property (ev && chime_q && rpt_q == 8'h00);
endmodule : rca_top

// ### test/rca_top_tb_top.sv
// self-checking bench for the clock/calendar unit
`timescale 1ns/1ps
module rca_top_tb_top;
  import rca_pkg::*;
  logic i_clk_sys; // system clock
  logic i_srst; // synchronous reset
  logic i_por; // power-on reset
  logic i_xtal_tick; // crystal pulse
  rca_bus_type i_bus; // register bus request
  logic [DW-1:0] o_rdata; // read data
  logic o_pin; // clock pin level
  logic o_pin_oe; // clock pin drive
  logic o_alarm_event; // alarm pulse
  int failures = 0; // mismatches seen
  int cmp_count = 0; // comparisons made
  int cyc = 0; // free cycle count
  int t0 = 0; // mark of last prescaler restart

  rca_top rca_top_inst (
    .i_clk_sys(i_clk_sys),
    .i_srst(i_srst),
    .i_por(i_por),
    .i_xtal_tick(i_xtal_tick),
    .i_bus(i_bus),
    .o_rdata(o_rdata),
    .o_pin(o_pin),
    .o_pin_oe(o_pin_oe),
    .o_alarm_event(o_alarm_event)
  );

  // clock generator
  always #20 i_clk_sys = ~i_clk_sys;

  // cycle counter for timed reads
  always @(posedge i_clk_sys) begin
    cyc <= cyc + 1;
  end

  // one comparison, counted
  task automatic chk(input string name, input logic [DW-1:0] exp,
                     input logic [DW-1:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // single-cycle write strobe
  task automatic wr(input logic [AW-1:0] a, input logic [DW-1:0] d, input logic [1:0] be);
    @(posedge i_clk_sys);
    i_bus <= {a, d, be, 1'b1, 1'b0};
    @(posedge i_clk_sys);
    i_bus <= '0;
  endtask : wr

  // single-cycle read, data taken in the following cycle
  task automatic rchk(input logic [AW-1:0] a, input logic [DW-1:0] exp, input string name);
    @(posedge i_clk_sys);
    i_bus <= {a, 16'h0000, 2'b00, 1'b0, 1'b1};
    @(posedge i_clk_sys);
    i_bus <= '0;
    #1;
    chk(name, exp, o_rdata);
  endtask : rchk

  // key pair, then the config write that keeps the unlock bit
  task automatic unlock_cfg(input logic [DW-1:0] v);
    wr(A_KEY, {8'h00, KEY_FIRST}, 2'b01);
    wr(A_KEY, {8'h00, KEY_SECOND}, 2'b01);
    wr(A_CFG, v, 2'b11);
  endtask : unlock_cfg

  // pin state a few cycles on
  task automatic pchk(input logic oe, input logic pin);
    repeat (3) @(posedge i_clk_sys);
    #1;
    chk("pin oe/level", {14'h0000, oe, pin}, {14'h0000, o_pin_oe, o_pin});
  endtask : pchk

  // wait relative to the last prescaler restart
  task automatic wait_to(input int n);
    while (cyc < t0 + n) begin
      @(posedge i_clk_sys);
    end
  endtask : wait_to

  // bounded wait for one alarm pulse
  task automatic wait_evt();
    int n;
    n = 0;
    do begin
      @(posedge i_clk_sys);
      #1;
      n++;
    end while (o_alarm_event !== 1'b1 && n < 17000);
    chk("alarm event", 16'h0001, {15'h0000, o_alarm_event});
  endtask : wait_evt

  // counts and verdict, ends the run
  task automatic print_verdict();
    $display("comparisons %0d failures %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : print_verdict

  // hang guard, a little above the expected run length
  initial begin
    repeat (95000) @(posedge i_clk_sys);
    failures++;
    print_verdict();
  end

  // main sequence
  initial begin
    i_clk_sys = 1'b0;
    i_srst = 1'b1;
    i_por = 1'b1;
    i_xtal_tick = 1'b0;
    i_bus = '0;
    repeat (6) @(posedge i_clk_sys);
    i_srst <= 1'b0;
    i_por <= 1'b0;
    // reset values and an unmapped place
    rchk(A_CFG, 16'h0000, "config reset");
    rchk(A_PAD, 16'h0000, "pad reset");
    rchk(A_ALCFG, 16'h0000, "alarm cfg reset");
    wr(3'h6, 16'hffff, 2'b11);
    rchk(3'h6, 16'h0000, "unmapped");
    // locked: enable ignored, window write blocked, pointer still steps
    wr(A_CFG, 16'h8300, 2'b11);
    rchk(A_CFG, 16'h0300, "enable while locked");
    wr(A_TVAL, 16'h0042, 2'b11);
    rchk(A_CFG, 16'h0200, "pointer step on write");
    wr(A_CFG, 16'h0300, 2'b11);
    rchk(A_TVAL, 16'h0000, "year blocked");
    // unlock, then a plain window read moves the pointer
    unlock_cfg(16'h2300);
    rchk(A_CFG, 16'h2300, "unlocked");
    rchk(A_TVAL, 16'h0000, "year still reset");
    rchk(A_CFG, 16'h2200, "pointer step on read");
    // fill every window slot
    unlock_cfg(16'h2300);
    wr(A_TVAL, 16'hff42, 2'b11);
    wr(A_TVAL, 16'h1225, 2'b11);
    wr(A_TVAL, 16'h0513, 2'b11);
    wr(A_TVAL, 16'h3407, 2'b11);
    unlock_cfg(16'h2300);
    rchk(A_TVAL, 16'h0042, "year");
    rchk(A_TVAL, 16'h0125, "month/day");
    rchk(A_TVAL, 16'h0513, "weekday/hours");
    rchk(A_TVAL, 16'h3407, "min/sec");
    rchk(A_TVAL, 16'h3407, "pointer held at 00");
    // trim survives a system reset
    unlock_cfg(16'h2080);
    @(posedge i_clk_sys);
    i_srst <= 1'b1;
    @(posedge i_clk_sys);
    i_srst <= 1'b0;
    rchk(A_CFG, 16'h2080, "config after srst");
    // alarm window pointer walk including the unimplemented slot
    wr(A_ALCFG, 16'h0300, 2'b11);
    rchk(A_AVAL, 16'h0000, "alarm slot 11");
    rchk(A_AVAL, 16'h0101, "alarm month/day");
    rchk(A_AVAL, 16'h0000, "alarm wd/hr");
    rchk(A_ALCFG, 16'h0000, "alarm pointer 00");
    // pin gating, seconds clock selected
    wr(A_PAD, 16'h0002, 2'b11);
    unlock_cfg(16'h2400);
    pchk(1'b1, 1'b1);
    unlock_cfg(16'h2000);
    pchk(1'b0, 1'b0);
    // running time: half flag, ripple window; crystal pulse from a clock edge
    @(posedge i_clk_sys);
    i_xtal_tick <= 1'b1;
    unlock_cfg(16'ha400);
    wr(A_TVAL, 16'h0000, 2'b01);
    t0 = cyc;
    wait_to(32'h2000);
    rchk(A_CFG, 16'ha400, "first half");
    chk("seconds clock high", 16'h0001, {15'h0000, o_pin});
    wait_to(32'h7ff0);
    rchk(A_CFG, 16'hbc00, "ripple window");
    chk("seconds clock low", 16'h0000, {15'h0000, o_pin});
    // warning set: read the window twice, both reads must agree
    rchk(A_TVAL, 16'h0000, "first of two reads");
    rchk(A_TVAL, 16'h0000, "second of two reads");
    wr(A_TVAL, 16'h0000, 2'b01);
    t0 = cyc;
    rchk(A_CFG, 16'ha400, "half cleared by write");
    // alarm every half second, one repeat, then self-disable
    wr(A_PAD, 16'h0000, 2'b11);
    wr(A_ALCFG, 16'h8001, 2'b11);
    wait_evt();
    pchk(1'b1, 1'b1);
    rchk(A_ALCFG, 16'h8000, "repeat decrement");
    wait_evt();
    rchk(A_ALCFG, 16'h0000, "alarm self-clear");
    rchk(A_TVAL, 16'h0001, "second advanced");
    // chime wraps the repeat count
    wr(A_ALCFG, 16'hc000, 2'b11);
    wait_evt();
    rchk(A_ALCFG, 16'hc0ff, "chime wrap");
    wr(A_ALCFG, 16'h0000, 2'b11);
    print_verdict();
  end
endmodule : rca_top_tb_top
